// ===== logic/dshp_pkg.sv
package dshp_pkg;

    // ****************************************************************
    // frame and converter word
    // ****************************************************************
    localparam int            WORD_W     = 24;
    localparam int            CNT_W      = 5;
    localparam logic [4:0]    CNT_FULL   = 5'h18;
    localparam logic [4:0]    CNT_OVER   = 5'h19;
    localparam logic [4:0]    CNT_ZERO   = 5'h00;
    localparam logic [23:0]   ZERO_CODE  = 24'h00_0000;
    localparam logic [23:0]   MID_CODE   = 24'h80_0000;
    localparam int            FIFO_DEPTH = 8;

    // ****************************************************************
    // link timing
    // ****************************************************************
    localparam int SCLK_MAX_KHZ   = 25000;
    localparam int REF_CLK_KHZ    = 25000;
    localparam int REF_PERIOD_NS  = 1000000 / REF_CLK_KHZ;
    localparam int SCLK_PERIOD_NS = 1000000 / SCLK_MAX_KHZ;
    // each sclk level must be seen by four samples after the synchroniser
    localparam int SCLK_MIN_CYC   = 4;
    localparam int SCLK_MIN_NS    = SCLK_MIN_CYC * REF_PERIOD_NS;

    // ****************************************************************
    // pin synchroniser slots and reset levels
    // ****************************************************************
    localparam int          SY_SCLK = 0;
    localparam int          SY_CS   = 1;
    localparam int          SY_SIN  = 2;
    localparam int          SY_LOAD = 3;
    localparam int          SY_CLEAR = 4;
    localparam int          SY_RST  = 5;
    localparam int          SY_OPEN = 6;
    localparam int          SY_TEMP = 7;
    localparam int          SY_WDOG = 8;
    localparam int          SY_MID  = 9;
    localparam int          SY_W    = 10;
    localparam logic [9:0]  SY_RST_VAL = 10'h02a;

    typedef enum logic [0:0] {
        ST_IDLE  = 1'b0,
        ST_SHIFT = 1'b1
    } dshp_state_t;

endpackage : dshp_pkg

// ===== logic/dshp_fifo.sv
`timescale 1ns/1ps
module dshp_fifo #(
    parameter int W = 24,   // word width
    parameter int D = 8     // depth
) (
    input  wire logic         clk,        // clock
    input  wire logic         rst_b,      // async reset, active low
    input  wire logic         flush,      // synchronous empty
    input  wire logic         in_valid,   // write request
    output      logic         in_ready,   // room for a word
    input  wire logic [W-1:0] in_data,    // write word
    output      logic         out_valid,  // head word present
    input  wire logic         out_ready,  // consumer takes head
    output      logic [W-1:0] out_data    // head word, registered
);
    localparam int AW = $clog2(D);

    logic [W-1:0]  mem [D];
    logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
    logic [AW:0]   cnt_ff, nxt_cnt;
    logic          ov_ff, nxt_ov;
    logic [W-1:0]  od_ff, nxt_od;
    logic          push, pop;

    assign in_ready  = (cnt_ff != (AW+1)'(D)) && !flush;
    assign out_valid = ov_ff;
    assign out_data  = od_ff;

    always_comb begin
        push    = in_valid && in_ready;
        pop     = (!ov_ff || out_ready) && (cnt_ff != '0);
        nxt_wr  = push ? wr_ff + 1'b1 : wr_ff;
        nxt_rd  = pop ? rd_ff + 1'b1 : rd_ff;
        nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        nxt_ov  = pop ? 1'b1 : (out_ready ? 1'b0 : ov_ff);
        nxt_od  = pop ? mem[rd_ff] : od_ff;
        if (flush) begin
            nxt_wr  = '0;
            nxt_rd  = '0;
            nxt_cnt = '0;
            nxt_ov  = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ff] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
            ov_ff  <= 1'b0;
            od_ff  <= '0;
        end else begin
            wr_ff  <= nxt_wr;
            rd_ff  <= nxt_rd;
            cnt_ff <= nxt_cnt;
            ov_ff  <= nxt_ov;
            od_ff  <= nxt_od;
        end
    end

endmodule : dshp_fifo

// ===== logic/dshp_port.sv
`timescale 1ns/1ps
module dshp_port (
    input  wire logic                 ref_clk,        // 25 MHz clock
    input  wire logic                 rst_b,          // async reset
    input  wire logic                 sclk_in,        // serial clock pin
    input  wire logic                 cs_n,           // chip select pin
    input  wire logic                 serial_in,      // serial data pin
    output      logic                 serial_out,     // serial data out
    output      logic                 serial_out_oe,  // drive serial_out
    input  wire logic                 load_output_n,  // load strobe pin
    input  wire logic                 clear_in,       // clear level pin
    input  wire logic                 clear_mid_sel,  // clear to mid code
    input  wire logic                 reset_pin_n,    // device reset pin
    input  wire logic                 open_circuit,   // alarm source
    input  wire logic                 over_temp,      // alarm source
    input  wire logic                 wdog_timeout,   // alarm source
    output      logic                 alarm_out,      // alarm pin level
    output      logic                 alarm_oe,       // alarm pulls low
    output      logic [dshp_pkg::WORD_W-1:0] dac_code,  // converter code
    output      logic                 word_dropped    // frame lost, pulse
);
    import dshp_pkg::*;

    // ****************************************************************
    // edge helpers
    // ****************************************************************
    function automatic logic fell(input logic prev, input logic cur);
        fell = prev && !cur;
    endfunction : fell

    function automatic logic rose(input logic prev, input logic cur);
        rose = !prev && cur;
    endfunction : rose

    // ****************************************************************
    // pin synchroniser
    // ****************************************************************
    logic [SY_W-1:0] raw, sy1_ff, sy2_ff;
    logic            sclk_d_ff, cs_d_ff;

    assign raw = {clear_mid_sel, wdog_timeout, over_temp, open_circuit,
                  reset_pin_n, clear_in, load_output_n, serial_in,
                  cs_n, sclk_in};

    genvar g;
    generate
        for (g = 0; g < SY_W; g++) begin : g_sync
            always_ff @(posedge ref_clk or negedge rst_b) begin
                if (!rst_b) begin
                    sy1_ff[g] <= SY_RST_VAL[g];
                    sy2_ff[g] <= SY_RST_VAL[g];
                end else begin
                    sy1_ff[g] <= raw[g];
                    sy2_ff[g] <= sy1_ff[g];
                end
            end
        end
    endgenerate

    logic sclk_s, cs_s, sin_s, load_s, clear_s, srst, mid_s, alarm_any;
    logic sclk_fall, cs_fall, cs_rise;

    always_comb begin
        sclk_s    = sy2_ff[SY_SCLK];
        cs_s      = sy2_ff[SY_CS];
        sin_s     = sy2_ff[SY_SIN];
        load_s    = sy2_ff[SY_LOAD];
        clear_s   = sy2_ff[SY_CLEAR];
        mid_s     = sy2_ff[SY_MID];
        srst      = !sy2_ff[SY_RST];
        alarm_any = sy2_ff[SY_OPEN] | sy2_ff[SY_TEMP] | sy2_ff[SY_WDOG];
        sclk_fall = fell(sclk_d_ff, sclk_s);
        cs_fall   = fell(cs_d_ff, cs_s);
        cs_rise   = rose(cs_d_ff, cs_s);
    end

    // ****************************************************************
    // serial shifter
    // ****************************************************************
    dshp_state_t       state_ff, nxt_state;
    logic [CNT_W-1:0]  cnt_ff, nxt_cnt;
    logic [WORD_W-1:0] rx_ff, nxt_rx, tx_ff, nxt_tx, rb_ff, nxt_rb;
    logic              so_ff, nxt_so, drop_ff, nxt_drop;
    logic              frame_done, fifo_in_ready;

    always_comb begin
        nxt_state  = state_ff;
        nxt_cnt    = cnt_ff;
        nxt_rx     = rx_ff;
        nxt_tx     = tx_ff;
        nxt_rb     = rb_ff;
        nxt_so     = so_ff;
        nxt_drop   = 1'b0;
        frame_done = (state_ff == ST_SHIFT) && cs_rise && (cnt_ff == CNT_FULL);
        case (state_ff)
            ST_IDLE: begin
                if (cs_fall) begin
                    nxt_state = ST_SHIFT;
                    nxt_cnt   = CNT_ZERO;
                    nxt_so    = rb_ff[WORD_W-1];
                    nxt_tx    = {rb_ff[WORD_W-2:0], 1'b0};
                end
            end
            ST_SHIFT: begin
                if (cs_rise) begin
                    nxt_state = ST_IDLE;
                    if (frame_done && fifo_in_ready) begin
                        nxt_rb = rx_ff;
                    end
                    nxt_drop = frame_done && !fifo_in_ready;
                end else if (sclk_fall) begin
                    nxt_rx = {rx_ff[WORD_W-2:0], sin_s};
                    nxt_cnt = (cnt_ff == CNT_OVER) ? cnt_ff : cnt_ff + 1'b1;
                    nxt_so = tx_ff[WORD_W-1];
                    nxt_tx = {tx_ff[WORD_W-2:0], 1'b0};
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
        if (srst) begin
            nxt_state = ST_IDLE;
            nxt_cnt   = CNT_ZERO;
            nxt_rx    = ZERO_CODE;
            nxt_tx    = ZERO_CODE;
            nxt_rb    = ZERO_CODE;
            nxt_so    = 1'b0;
            nxt_drop  = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff  <= ST_IDLE;
            cnt_ff    <= CNT_ZERO;
            rx_ff     <= ZERO_CODE;
            tx_ff     <= ZERO_CODE;
            rb_ff     <= ZERO_CODE;
            so_ff     <= 1'b0;
            drop_ff   <= 1'b0;
            sclk_d_ff <= SY_RST_VAL[SY_SCLK];
            cs_d_ff   <= SY_RST_VAL[SY_CS];
        end else begin
            state_ff  <= nxt_state;
            cnt_ff    <= nxt_cnt;
            rx_ff     <= nxt_rx;
            tx_ff     <= nxt_tx;
            rb_ff     <= nxt_rb;
            so_ff     <= nxt_so;
            drop_ff   <= nxt_drop;
            sclk_d_ff <= sclk_s;
            cs_d_ff   <= cs_s;
        end
    end

    // ****************************************************************
    // word queue and converter register
    // ****************************************************************
    logic              q_valid, q_ready;
    logic [WORD_W-1:0] q_data;
    logic [WORD_W-1:0] dreg_ff, nxt_dreg, code_ff, nxt_code;
    logic              alarm_ff, nxt_alarm;

    assign q_ready = !load_s && !srst;

    dshp_fifo #(
        .W (WORD_W),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .clk       (ref_clk),
        .rst_b     (rst_b),
        .flush     (srst),
        .in_valid  (frame_done),
        .in_ready  (fifo_in_ready),
        .in_data   (rx_ff),
        .out_valid (q_valid),
        .out_ready (q_ready),
        .out_data  (q_data)
    );

    always_comb begin
        nxt_dreg  = dreg_ff;
        if (q_valid && q_ready) begin
            nxt_dreg = q_data;
        end
        nxt_code  = clear_s ? (mid_s ? MID_CODE : ZERO_CODE) : dreg_ff;
        nxt_alarm = alarm_any;
        if (srst) begin
            nxt_dreg  = ZERO_CODE;
            nxt_code  = ZERO_CODE;
            nxt_alarm = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            dreg_ff  <= ZERO_CODE;
            code_ff  <= ZERO_CODE;
            alarm_ff <= 1'b0;
        end else begin
            dreg_ff  <= nxt_dreg;
            code_ff  <= nxt_code;
            alarm_ff <= nxt_alarm;
        end
    end

    assign serial_out_oe = (state_ff == ST_SHIFT) && !cs_s;
    assign serial_out    = so_ff;
    assign alarm_out     = 1'b0;
    assign alarm_oe      = alarm_ff;
    assign dac_code      = code_ff;
    assign word_dropped  = drop_ff;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    sequence s_full_close;
        (state_ff == ST_SHIFT) && cs_rise && (cnt_ff == CNT_FULL) && !srst;
    endsequence

    sequence s_bit_in;
        (state_ff == ST_SHIFT) && sclk_fall && !cs_rise && !srst;
    endsequence

    a_shift_capture: assert property (
        s_bit_in |=> rx_ff[0] == $past(sin_s)
                     && rx_ff[WORD_W-1:1] == $past(rx_ff[WORD_W-2:0]))
        else $error("bit not captured on falling edge");

    a_out_bit: assert property (
        s_bit_in |=> so_ff == $past(tx_ff[WORD_W-1])
                     ##1 ($stable(so_ff) || $past(srst)))
        else $error("serial_out not advanced at falling edge");

    a_rate_period: assert property (
        s_bit_in |=> !sclk_fall[*2])
        else $error("sclk edges closer than sampling allows");

    a_cs_ignore: assert property (
        (state_ff == ST_IDLE && !cs_fall) |=> $stable(rx_ff) || $past(srst))
        else $error("shifter moved while deselected");

    a_oe_release: assert property (
        cs_s |-> !serial_out_oe)
        else $error("serial_out driven while deselected");

    a_load_update: assert property (
        (q_valid && !load_s && !srst) |=> dreg_ff == $past(q_data)
                                           ##1 code_ff == $past(dreg_ff)
                                               || $past(clear_s) || $past(srst))
        else $error("load strobe did not update converter");

    a_clear_force: assert property (
        (clear_s && !srst) |=> code_ff == ($past(mid_s) ? MID_CODE : ZERO_CODE))
        else $error("clear did not force output code");

    a_reset_pin: assert property (
        srst |=> state_ff == ST_IDLE && cnt_ff == CNT_ZERO
                 && dreg_ff == ZERO_CODE && !q_valid)
        else $error("reset pin did not reset logic");

    a_alarm_pin: assert property (
        alarm_any && !srst |=> alarm_oe ##0 !alarm_out)
        else $error("alarm not driven low");

    a_frame_push: assert property (
        s_full_close |-> frame_done ##1 (rb_ff == $past(rx_ff) || drop_ff))
        else $error("full frame not acted on at deselect");

    a_short_frame: assert property (
        (cs_rise && cnt_ff != CNT_FULL) |-> !frame_done ##1 !drop_ff)
        else $error("short or long frame was acted on");

endmodule : dshp_port

// ===== verification/dshp_host_model.sv
`timescale 1ns/1ps
module dshp_host_model (
    output      logic sclk,  // serial clock, stands high between frames
    output      logic cs_n,  // chip select, active low
    output      logic mosi,  // data towards the device
    input  wire logic miso   // resolved serial_out line
);
    // ****************************************************************
    // link idle levels
    // ****************************************************************
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        mosi = 1'b0;
    end

    // ****************************************************************
    // one frame, msb first, readback taken at each falling edge
    // ****************************************************************
    // rate and framing
    task automatic send(input logic [23:0] w, input int nbits,
                        output logic [23:0] rb);
        rb = 24'h00_0000;
        cs_n = 1'b0;
        #160;
        for (int i = 0; i < nbits; i++) begin
            mosi = w[23-i];
            #160;
            sclk = 1'b0;
            rb = {rb[22:0], miso};
            #160;
            sclk = 1'b1;
        end
        #160;
        cs_n = 1'b1;
        // released line no longer shows the last bit
        mosi = ~mosi;
        #200;
    endtask : send
endmodule : dshp_host_model

// ===== verification/dac_serial_host_port_tb.sv
`timescale 1ns/1ps
module dac_serial_host_port_tb;
    import dshp_pkg::*;
    logic ref_clk, rst_b, sclk_in, cs_n, serial_in, serial_out;
    logic serial_out_oe, load_output_n, clear_in, clear_mid_sel;
    logic reset_pin_n, open_circuit, over_temp, wdog_timeout;
    logic alarm_out, alarm_oe, word_dropped, sout_last, miso;
    logic [WORD_W-1:0] dac_code, rb;
    int err_count, n_checks, drop_cnt, cyc;

    dshp_port u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .sclk_in(sclk_in),
        .cs_n(cs_n), .serial_in(serial_in), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe), .load_output_n(load_output_n),
        .clear_in(clear_in), .clear_mid_sel(clear_mid_sel),
        .reset_pin_n(reset_pin_n), .open_circuit(open_circuit),
        .over_temp(over_temp), .wdog_timeout(wdog_timeout),
        .alarm_out(alarm_out), .alarm_oe(alarm_oe), .dac_code(dac_code),
        .word_dropped(word_dropped));
    dshp_host_model u_host (.sclk(sclk_in), .cs_n(cs_n), .mosi(serial_in),
        .miso(miso));

    // ****************************************************************
    // clock, released data line, drop counter, timeout
    // ****************************************************************
    initial ref_clk = 1'b0;
    always #20 ref_clk = ~ref_clk;
    assign miso = serial_out_oe ? serial_out : ~sout_last;
    always @(posedge ref_clk) begin
        if (serial_out_oe === 1'b1) sout_last <= serial_out;
        if (word_dropped === 1'b1) drop_cnt++;
        cyc++;
        if (cyc == 10000) begin
            err_count++;
            end_of_test();
        end
    end

    // ****************************************************************
    // compares and helpers
    // ****************************************************************
    task automatic chk24(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t word %h expected %h", $time, got, exp);
        end
    endtask : chk24
    task automatic chk1(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chk1
    task automatic cyc_wait(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc_wait
    task automatic load(input int n);
        cyc_wait(1);
        load_output_n = 1'b0;
        cyc_wait(n);
        load_output_n = 1'b1;
        cyc_wait(6);
    endtask : load

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_frame_load();
        chk1(serial_out_oe, 1'b0);
        u_host.send(24'hA5_C396, 24, rb);
        chk1(serial_out_oe, 1'b0);
        load(2);
        chk24(dac_code, 24'hA5_C396);
        u_host.send(24'h3C_5A0F, 24, rb);
        chk24(rb, 24'hA5_C396);
        load(2);
        chk24(dac_code, 24'h3C_5A0F);
    endtask : t_frame_load
    task automatic t_short_frame();
        u_host.send(24'hFF_FFFF, 23, rb);
        load(2);
        chk24(dac_code, 24'h3C_5A0F);
    endtask : t_short_frame
    task automatic t_clear();
        for (int s = 0; s < 2; s++) begin
            clear_mid_sel = s[0];
            clear_in = 1'b1;
            cyc_wait(5);
            chk24(dac_code, s ? MID_CODE : ZERO_CODE);
            clear_in = 1'b0;
            cyc_wait(5);
            chk24(dac_code, 24'h3C_5A0F);
        end
    endtask : t_clear
    task automatic t_alarm();
        for (int i = 0; i < 4; i++) begin
            {open_circuit, over_temp, wdog_timeout} = 3'b100 >> i;
            cyc_wait(5);
            chk1(alarm_oe, i < 3);
            chk1(alarm_out, 1'b0);
        end
    endtask : t_alarm
    task automatic t_fifo_full();
        drop_cnt = 0;
        for (int i = 0; i < 10; i++) begin
            u_host.send(24'h10_0000 + 24'(i), 24, rb);
        end
        cyc_wait(4);
        chk1(drop_cnt == 1, 1'b1);
        load(20);
        chk24(dac_code, 24'h10_0008);
    endtask : t_fifo_full
    task automatic t_reset_pin();
        u_host.send(24'h77_1234, 24, rb);
        open_circuit = 1'b1;
        cyc_wait(5);
        reset_pin_n = 1'b0;
        cyc_wait(6);
        chk24(dac_code, ZERO_CODE);
        chk1(alarm_oe, 1'b0);
        reset_pin_n = 1'b1;
        open_circuit = 1'b0;
        cyc_wait(6);
        load(2);
        chk24(dac_code, ZERO_CODE);
    endtask : t_reset_pin

    // ****************************************************************
    // verdict
    // ****************************************************************
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test

    initial begin
        {err_count, n_checks, drop_cnt, cyc} = '0;
        {rst_b, clear_in, clear_mid_sel, sout_last} = 4'h0;
        {open_circuit, over_temp, wdog_timeout} = 3'b000;
        load_output_n = 1'b1;
        reset_pin_n = 1'b1;
        cyc_wait(8);
        rst_b = 1'b1;
        cyc_wait(4);
        t_frame_load();
        t_short_frame();
        t_clear();
        t_alarm();
        t_fifo_full();
        t_reset_pin();
        end_of_test();
    end
endmodule : dac_serial_host_port_tb
